//--- hdl/pgs_supervisor.sv
`timescale 1ns/10ps
`include "pgs_defines.svh"

module pgs_supervisor #(
  parameter int ON_RESET_CYC = `PGS_ON_RESET_CYCLES,
  parameter int BREAKER_CLR_CYC = `PGS_BREAKER_CLR_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic ON,
  input wire logic FAULT_I,
  input wire logic POWER_GOOD_IN,
  input wire pgs_pkg::pgs_cfg_t CFG,
  output logic FAULT_O,
  output logic FAULT_OE,
  output pgs_pkg::pgs_status_t STATUS,
  output logic PG_SAMPLE,
  output logic CYCLE_END
);
  import pgs_pkg::*;

  localparam int CW = `PGS_CNT_W;
  localparam logic [CW-1:0] ON_RST_LIM = CW'(ON_RESET_CYC);
  localparam logic [CW-1:0] BRK_CLR_LIM = CW'(BREAKER_CLR_CYC);
  localparam logic [CW-1:0] FILT_OFFSET = CW'(`PGS_FILTER_OFFSET_CYCLES - 1);
  localparam logic [`PGS_HALF_W-1:0] LAST_HALF = `PGS_HALF_W'(`PGS_HALF_RAMPS - 1);

  function automatic logic is_powered(input pgs_state_t s);
    is_powered = (s == ST_CYCLE2) || (s == ST_TIMEOUT) || (s == ST_FILTER);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic on_hi;
  logic fault_hi;
  logic pg_hi;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {ON, FAULT_I, POWER_GOOD_IN};
      sync2_reg <= sync1_reg;
    end
  end

  assign on_hi = sync2_reg[2];
  assign fault_hi = sync2_reg[1];
  assign pg_hi = sync2_reg[0];

  // ----------------------------------------
  // on-low timing
  // ----------------------------------------
  logic [CW-1:0] on_low_reg;
  logic logic_rst;
  logic breaker_clr;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      on_low_reg <= '0;
    end
    else if (on_hi)
    begin
      on_low_reg <= '0;
    end
    else if (on_low_reg < BRK_CLR_LIM)
    begin
      on_low_reg <= on_low_reg + 1'b1;
    end
  end

  assign logic_rst = !on_hi && (on_low_reg >= ON_RST_LIM);
  assign breaker_clr = !on_hi && (on_low_reg >= BRK_CLR_LIM);

  // ----------------------------------------
  // delay counters
  // ----------------------------------------
  pgs_state_t state_reg;
  pgs_state_t state_next;
  logic [`PGS_HALF_W-1:0] half_reg;
  logic cyc_run;
  logic cyc_done;
  logic [CW-1:0] cyc_cnt;
  logic ramp_run;
  logic ramp_done;
  logic [CW-1:0] ramp_cnt;
  logic [CW-1:0] ramp_lim;
  logic filt_run;
  logic filt_done;
  logic [CW-1:0] filt_cnt;
  logic [CW-1:0] filt_lim;
  logic timeout_end;

  assign cyc_run = (state_reg == ST_CYCLE1) || (state_reg == ST_CYCLE2);

  // one counter per capacitor; load L gives L+1 clocks
  pgs_counter #(.W(CW)) u_cycle (
    .clk(SYS_CLK),
    .rst(RST),
    .run(cyc_run),
    .limit(CFG.cycle_load),
    .count(cyc_cnt),
    .done(cyc_done)
  );

  // stopped on the reset edge too, so the ramp never leaves a stale count behind
  assign ramp_run = (state_reg == ST_TIMEOUT) && fault_hi && !logic_rst;
  // first ramp climbs from ground, so it has its own load
  assign ramp_lim = (half_reg == '0) ? CFG.ramp_first_load : CFG.ramp_half_load;

  pgs_counter #(.W(CW)) u_ramp (
    .clk(SYS_CLK),
    .rst(RST),
    .run(ramp_run),
    .limit(ramp_lim),
    .count(ramp_cnt),
    .done(ramp_done)
  );

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      half_reg <= '0;
    end
    else if (!ramp_run || timeout_end)
    begin
      half_reg <= '0;
    end
    else if (ramp_done)
    begin
      half_reg <= half_reg + 1'b1;
    end
  end

  assign timeout_end = ramp_done && (half_reg == LAST_HALF);

  // grounded node never charges: filter can never trip
  assign filt_run = (state_reg == ST_FILTER) && fault_hi && !pg_hi
    && !CFG.filter_grounded;
  assign filt_lim = CFG.filter_load + FILT_OFFSET;

  pgs_counter #(.W(CW)) u_filter (
    .clk(SYS_CLK),
    .rst(RST),
    .run(filt_run),
    .limit(filt_lim),
    .count(filt_cnt),
    .done(filt_done)
  );

  // ----------------------------------------
  // trip sources and breaker latch
  // ----------------------------------------
  logic pg_trip;
  logic ext_trip;
  logic breaker_reg;
  logic breaker_next;

  assign pg_trip = (timeout_end && !pg_hi) || filt_done;
  assign ext_trip = is_powered(state_reg) && !fault_hi;
  // set beats clear when both land together
  assign breaker_next = (pg_trip || ext_trip) ? 1'b1 : (breaker_clr ? 1'b0 : breaker_reg);

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      breaker_reg <= 1'b0;
    end
    else
    begin
      breaker_reg <= breaker_next;
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    if (logic_rst)
    begin
      state_next = ST_IDLE;
    end
    else if (pg_trip || ext_trip)
    begin
      state_next = ST_OFF;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE: if (on_hi && !breaker_reg) state_next = ST_CYCLE1;
        ST_CYCLE1: if (cyc_done) state_next = ST_GAP;
        ST_GAP: if (fault_hi) state_next = ST_CYCLE2;
        ST_CYCLE2: if (cyc_done) state_next = fault_hi ? ST_TIMEOUT : ST_HOLD;
        ST_HOLD: state_next = ST_HOLD;
        ST_TIMEOUT: if (timeout_end) state_next = ST_FILTER;
        ST_FILTER: state_next = ST_FILTER;
        ST_OFF: state_next = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  pgs_status_t status_reg;
  logic fault_oe_reg;
  logic pg_sample_reg;
  logic cycle_end_reg;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      status_reg <= '0;
      fault_oe_reg <= 1'b0;
      pg_sample_reg <= 1'b0;
      cycle_end_reg <= 1'b0;
    end
    else
    begin
      // built from next values so the gate drops on the trip edge
      status_reg.gate_on <= is_powered(state_next) && !breaker_next;
      status_reg.breaker_latch <= breaker_next;
      status_reg.timeout_run <= (state_next == ST_TIMEOUT);
      status_reg.filter_run <= (state_next == ST_FILTER);
      fault_oe_reg <= breaker_next;
      pg_sample_reg <= timeout_end;
      cycle_end_reg <= cyc_done;
    end
  end

  assign STATUS = status_reg;
  assign FAULT_OE = fault_oe_reg;
  assign FAULT_O = 1'b0;
  assign PG_SAMPLE = pg_sample_reg;
  assign CYCLE_END = cycle_end_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_last_ramp;
    (state_reg == ST_TIMEOUT) ##0 timeout_end;
  endsequence

  sequence s_good_sample;
    s_last_ramp ##0 (pg_hi && fault_hi && !logic_rst);
  endsequence

  a_cycle_idle_zero: assert property (!cyc_run |=> cyc_cnt == '0)
    else $error("cycle timer not held at zero");
  a_cycle_advance: assert property (cyc_run && !cyc_done && !logic_rst && !ext_trip
    |=> cyc_cnt == $past(cyc_cnt) + 1'b1)
    else $error("cycle timer did not advance");
  a_cycle_wrap_zero: assert property (cyc_done |=> cyc_cnt == '0)
    else $error("cycle timer not cleared at terminal");
  a_timeout_enable: assert property (state_reg == ST_CYCLE2 && cyc_done && fault_hi
    && !logic_rst |=> state_reg == ST_TIMEOUT ##1 ramp_run || !fault_hi || logic_rst)
    else $error("timeout not enabled after second cycle");
  a_timers_held: assert property (state_reg != ST_TIMEOUT |-> ramp_cnt == '0
    && half_reg == '0)
    else $error("timeout timer not held cleared");
  a_first_ramp: assert property (ramp_done && half_reg == '0
    |-> ramp_cnt == CFG.ramp_first_load)
    else $error("first ramp length wrong");
  a_bad_sample_trip: assert property (s_last_ramp ##0 !pg_hi
    |=> breaker_reg && FAULT_OE && !STATUS.gate_on)
    else $error("low power-good did not trip");
  a_good_sample_filter: assert property (s_good_sample
    |=> state_reg == ST_FILTER && STATUS.filter_run)
    else $error("filter not enabled after good sample");
  a_filter_restart: assert property (state_reg == ST_FILTER && pg_hi |=> filt_cnt == '0)
    else $error("filter timer not cleared");
  a_breaker_holds: assert property (breaker_reg && !breaker_clr |=> breaker_reg)
    else $error("breaker released early");
  a_logic_reset: assert property (logic_rst |=> state_reg == ST_IDLE)
    else $error("logic not reset by on low");

endmodule

//--- hdl/pgs_defines.svh
`ifndef PGS_DEFINES_SVH
`define PGS_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PGS_CLK_PERIOD_NS 10
`define PGS_ON_RESET_NS 10000
`define PGS_ON_RESET_CYCLES ((`PGS_ON_RESET_NS + `PGS_CLK_PERIOD_NS - 1) / `PGS_CLK_PERIOD_NS)
`define PGS_BREAKER_CLR_NS 120000
`define PGS_BREAKER_CLR_CYCLES \
  ((`PGS_BREAKER_CLR_NS + `PGS_CLK_PERIOD_NS - 1) / `PGS_CLK_PERIOD_NS)
`define PGS_FILTER_OFFSET_NS 5000
`define PGS_FILTER_OFFSET_CYCLES \
  ((`PGS_FILTER_OFFSET_NS + `PGS_CLK_PERIOD_NS - 1) / `PGS_CLK_PERIOD_NS)

// ----------------------------------------
// counts and widths
// ----------------------------------------
`define PGS_CNT_W 24
`define PGS_OSC_CYCLES 14
`define PGS_HALF_RAMPS (2 * `PGS_OSC_CYCLES)
`define PGS_HALF_W 5

`endif

//--- hdl/pgs_pkg.sv
`include "pgs_defines.svh"

package pgs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CYCLE1,
    ST_GAP,
    ST_CYCLE2,
    ST_HOLD,
    ST_TIMEOUT,
    ST_FILTER,
    ST_OFF
  } pgs_state_t;

  typedef struct packed {
    logic [`PGS_CNT_W-1:0] cycle_load;
    logic [`PGS_CNT_W-1:0] ramp_first_load;
    logic [`PGS_CNT_W-1:0] ramp_half_load;
    logic [`PGS_CNT_W-1:0] filter_load;
    logic filter_grounded;
  } pgs_cfg_t;

  typedef struct packed {
    logic gate_on;
    logic breaker_latch;
    logic timeout_run;
    logic filter_run;
  } pgs_status_t;

endpackage

//--- hdl/pgs_counter.sv
`timescale 1ns/10ps

module pgs_counter #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count,
  output logic done
);

  logic [W-1:0] count_reg;

  // ----------------------------------------
  // terminal detect
  // ----------------------------------------
  assign done = run && (count_reg == limit);
  assign count = count_reg;

  // ----------------------------------------
  // count, held at zero when idle
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= '0;
    end
    else if (!run || done)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule

//--- bench/pgs_pg_source.sv
`timescale 1ns/10ps

module pgs_pg_source (
  input wire logic clk,
  input wire logic supply_on,
  input wire logic [15:0] ramp_cyc,
  input wire logic drop,
  output logic pg
);
  // ----------------------------------------
  // supply monitor on the board rails
  // ----------------------------------------
  logic [15:0] up_cnt;

  // rails need ramp_cyc clocks of gate drive before regulation
  always @(posedge clk)
  begin
    if (!supply_on)
      up_cnt <= 16'h0000;
    else if (up_cnt < ramp_cyc)
      up_cnt <= up_cnt + 16'h0001;
  end

  // open-drain output with pull-up: high only when released
  assign pg = supply_on && (up_cnt >= ramp_cyc) && !drop;
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps

module tb;
  import pgs_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TO_CYC = 4 + 27 * 4;
  localparam int FLT_CYC = 20 + 500;
  logic sys_clk = 1'b0;
  logic rst, on, ext_fault, pg_drop, pg, fault_i, fault_o, fault_oe, pg_sample, cycle_end;
  logic [15:0] ramp;
  pgs_cfg_t cfg;
  pgs_status_t status;
  int err_count = 0;
  int n_tests = 0;
  int seed = 80;
  int n, w;

  always #5 sys_clk = ~sys_clk;
  // wired fault line: either party may pull it low
  assign fault_i = ~(fault_oe | ext_fault);

  pgs_supervisor #(.ON_RESET_CYC(10), .BREAKER_CLR_CYC(40)) dut (.SYS_CLK(sys_clk), .RST(rst),
    .ON(on), .FAULT_I(fault_i), .POWER_GOOD_IN(pg), .CFG(cfg), .FAULT_O(fault_o),
    .FAULT_OE(fault_oe), .STATUS(status), .PG_SAMPLE(pg_sample), .CYCLE_END(cycle_end));
  pgs_pg_source src (.clk(sys_clk), .supply_on(status.gate_on), .ramp_cyc(ramp),
    .drop(pg_drop), .pg(pg));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task test_done;
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // counts carry a small window for the pin synchronisers
  task chk_win(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
      err_count++;
    end
  endtask

  task automatic wait_ev(input int sel, input int bound, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit)
    begin
      @(negedge sys_clk);
      cnt++;
      case (sel)
        0: hit = (cycle_end === 1'b1);
        1: hit = (pg_sample === 1'b1);
        default: hit = (status.breaker_latch === 1'b1);
      endcase
      if (cnt > bound)
      begin
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cnt, bound);
        err_count++;
        test_done();
      end
    end
  endtask

  task run_up;
    on = 1'b1;
    wait_ev(0, 100, n);
    chk_bit(status.timeout_run, 1'b0);
    wait_ev(0, 100, n);
    chk_win(n, 8, 12);
    wait_ev(1, 300, n);
    chk_win(n, TO_CYC - 2, TO_CYC + 2);
  endtask

  task clear_breaker;
    on = 1'b0;
    repeat (50) @(negedge sys_clk);
    chk_bit(status.breaker_latch, 1'b0);
    chk_bit(fault_oe, 1'b0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    on = 1'b0;
    ext_fault = 1'b0;
    pg_drop = 1'b0;
    ramp = 16'h001E;
    cfg = {24'h000007, 24'h000003, 24'h000003, 24'h000014, 1'b0};
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    chk_bit(status.gate_on, 1'b0);
    run_up();
    repeat (3) @(negedge sys_clk);
    chk_bit(status.filter_run, 1'b1);
    chk_bit(status.gate_on, 1'b1);
    // back-to-back lows each under the limit must not add up
    for (int i = 0; i < 5; i++)
    begin
      w = (i < 2) ? 480 : 1 + ($unsigned($random(seed)) % 470);
      pg_drop = 1'b1;
      repeat (w) @(negedge sys_clk);
      pg_drop = 1'b0;
      repeat (20) @(negedge sys_clk);
      chk_bit(status.breaker_latch, 1'b0);
    end
    pg_drop = 1'b1;
    wait_ev(2, 700, n);
    chk_win(n, FLT_CYC - 1, FLT_CYC + 4);
    chk_bit(status.gate_on, 1'b0);
    chk_bit(fault_oe, 1'b1);
    chk_bit(fault_o, 1'b0);
    pg_drop = 1'b0;
    // short off pulse resets logic but keeps the breaker
    on = 1'b0;
    repeat (20) @(negedge sys_clk);
    on = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk_bit(status.breaker_latch, 1'b1);
    chk_bit(status.filter_run, 1'b0);
    clear_breaker();
    ramp = 16'h03E8;
    run_up();
    chk_bit(status.breaker_latch, 1'b1);
    chk_bit(status.gate_on, 1'b0);
    clear_breaker();
    ramp = 16'h001E;
    // fault held low through the first cycle: the second cycle must not start
    ext_fault = 1'b1;
    on = 1'b1;
    wait_ev(0, 100, n);
    repeat (50) @(negedge sys_clk);
    chk_bit(status.gate_on, 1'b0);
    chk_bit(status.timeout_run, 1'b0);
    ext_fault = 1'b0;
    wait_ev(0, 100, n);
    chk_bit(status.timeout_run, 1'b1);
    ext_fault = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk_bit(status.timeout_run, 1'b0);
    chk_bit(status.breaker_latch, 1'b1);
    ext_fault = 1'b0;
    clear_breaker();
    cfg.filter_grounded = 1'b1;
    run_up();
    repeat (3) @(negedge sys_clk);
    pg_drop = 1'b1;
    repeat (700) @(negedge sys_clk);
    chk_bit(status.breaker_latch, 1'b0);
    // node released with no filter load: the fixed offset alone must trip
    cfg.filter_grounded = 1'b0;
    cfg.filter_load = 24'h000000;
    wait_ev(2, 700, n);
    chk_win(n, 499, 504);
    pg_drop = 1'b0;
    test_done();
  end
endmodule
